// ### iwd_device.sv
// Watchdog device end: keyed index/data port, bank select, countdown and status
// Functional notes
// - Index port selects register, data port accesses
// - Unlock key written twice opens configuration
// - Lock key on index closes configuration
// - Bank code selects watchdog register set
// - Writing one to enable activates; reset disabled
// - Unit bit three: seconds default, minutes
// - Count 1 to 255; zero stops timer
// - Any count write restarts from value
// - Expiry raises interrupt/reset signal
// - Control bit six lets keyboard restart
// - Control bit five forces timeout, self-clears
// - Control bit four reads timeout status
// - Control bit seven lets mouse restart
`timescale 1ns/1ps
`default_nettype none
module iwd_device #(
  parameter int unsigned CYC_PER_SEC = iwd_pkg::CYC_PER_SEC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  iwd_if.dev        port,
  input  wire logic kbd_act,
  input  wire logic mouse_act,
  output logic      wdt_alarm
);

  localparam int unsigned PW = (CYC_PER_SEC > 1) ? $clog2(CYC_PER_SEC) : 1;
  localparam logic [PW-1:0] PRESC_LAST = PW'(CYC_PER_SEC - 1);
  localparam logic [iwd_pkg::MIN_W-1:0] MIN_LAST = iwd_pkg::MIN_W'(iwd_pkg::SEC_PER_MIN - 1);

  typedef struct packed {
    iwd_pkg::iwd_lock_e        lk;
    logic [7:0]                idx;
    logic [7:0]                bank;
    logic                      fen;
    logic [7:0]                unit;
    logic [7:0]                cnt_val;
    logic [7:0]                cnt;
    logic                      ms_en;
    logic                      kb_en;
    logic [3:0]                ctrl_lo;
    logic                      tout;
    logic [PW-1:0]             presc;
    logic [iwd_pkg::MIN_W-1:0] mins;
    logic                      ack;
    logic [7:0]                rdata;
  } iwd_dev_s;

  iwd_dev_s state_r;
  iwd_dev_s state_nxt;
  logic     take;
  logic     wdt_sel;
  logic     restart;
  logic     force_to;
  logic     clr_st;
  logic     kick;
  logic     expire;
  logic     unit_tick;

  localparam iwd_dev_s DEV_RST = '{
    lk:      iwd_pkg::LK_LOCKED,
    idx:     8'h00,
    bank:    iwd_pkg::BANK_RST,
    fen:     1'b0,
    unit:    iwd_pkg::UNIT_RST,
    cnt_val: iwd_pkg::COUNT_RST,
    cnt:     iwd_pkg::COUNT_RST,
    ms_en:   1'b0,
    kb_en:   1'b0,
    ctrl_lo: 4'h0,
    tout:    1'b0,
    presc:   '0,
    mins:    '0,
    ack:     1'b0,
    rdata:   iwd_pkg::RD_IDLE
  };

  always_comb begin
    state_nxt = state_r;
    state_nxt.ack = 1'b0;
    take      = port.io_req && !state_r.ack;
    wdt_sel   = (state_r.bank == iwd_pkg::BANK_WDT);
    restart   = 1'b0;
    force_to  = 1'b0;
    clr_st    = 1'b0;
    expire    = 1'b0;
    unit_tick = 1'b0;
    kick      = (kbd_act && state_r.kb_en) || (mouse_act && state_r.ms_en);

    // Host access: one acknowledge per request, a cycle after it is seen
    if (take) begin
      state_nxt.ack   = 1'b1;
      state_nxt.rdata = iwd_pkg::RD_IDLE;
      if (port.io_addr == iwd_pkg::IDX_PORT) begin
        if (port.io_we) begin
          unique case (state_r.lk)
            iwd_pkg::LK_LOCKED: begin
              if (port.io_wdata == iwd_pkg::KEY_UNLOCK) begin
                state_nxt.lk = iwd_pkg::LK_HALF;
              end
            end
            iwd_pkg::LK_HALF: begin
              // Second key must follow the first with nothing in between
              state_nxt.lk = (port.io_wdata == iwd_pkg::KEY_UNLOCK) ?
                             iwd_pkg::LK_OPEN : iwd_pkg::LK_LOCKED;
            end
            iwd_pkg::LK_OPEN: begin
              if (port.io_wdata == iwd_pkg::KEY_LOCK) begin
                state_nxt.lk = iwd_pkg::LK_LOCKED;
              end else begin
                state_nxt.idx = port.io_wdata;
              end
            end
          endcase
        end else begin
          if (state_r.lk == iwd_pkg::LK_HALF) begin
            state_nxt.lk = iwd_pkg::LK_LOCKED;
          end
          if (state_r.lk == iwd_pkg::LK_OPEN) begin
            state_nxt.rdata = state_r.idx;
          end
        end
      end else begin
        if (state_r.lk == iwd_pkg::LK_HALF) begin
          state_nxt.lk = iwd_pkg::LK_LOCKED;
        end
        // Locked data port reads idle high and drops writes
        if (port.io_addr == iwd_pkg::DAT_PORT && state_r.lk == iwd_pkg::LK_OPEN) begin
          if (port.io_we) begin
            if (state_r.idx == iwd_pkg::REG_BANK) begin
              state_nxt.bank = port.io_wdata;
            end else if (wdt_sel) begin
              unique case (state_r.idx)
                iwd_pkg::REG_FEN: begin
                  state_nxt.fen = (port.io_wdata == iwd_pkg::FEN_ON);
                end
                iwd_pkg::REG_UNIT: begin
                  state_nxt.unit = port.io_wdata;
                end
                iwd_pkg::REG_COUNT: begin
                  state_nxt.cnt_val = port.io_wdata;
                  restart = 1'b1;
                end
                iwd_pkg::REG_CTRL: begin
                  state_nxt.ms_en   = port.io_wdata[iwd_pkg::CTRL_MS_BIT];
                  state_nxt.kb_en   = port.io_wdata[iwd_pkg::CTRL_KB_BIT];
                  force_to          = port.io_wdata[iwd_pkg::CTRL_FRC_BIT];
                  clr_st            = port.io_wdata[iwd_pkg::CTRL_ST_BIT];
                  state_nxt.ctrl_lo = port.io_wdata[3:0];
                end
                default: begin
                end
              endcase
            end
          end else begin
            if (state_r.idx == iwd_pkg::REG_BANK) begin
              state_nxt.rdata = state_r.bank;
            end else if (wdt_sel) begin
              unique case (state_r.idx)
                iwd_pkg::REG_FEN: begin
                  state_nxt.rdata = {7'h00, state_r.fen};
                end
                iwd_pkg::REG_UNIT: begin
                  state_nxt.rdata = state_r.unit;
                end
                iwd_pkg::REG_COUNT: begin
                  state_nxt.rdata = state_r.cnt;
                end
                iwd_pkg::REG_CTRL: begin
                  // Force bit always reads back as zero
                  state_nxt.rdata = {state_r.ms_en, state_r.kb_en, 1'b0, state_r.tout,
                                     state_r.ctrl_lo};
                end
                default: begin
                end
              endcase
            end
          end
        end
      end
    end

    // Countdown: prescaler restarts with each reload so a period is never short
    if (restart) begin
      state_nxt.cnt   = port.io_wdata;
      state_nxt.presc = '0;
      state_nxt.mins  = '0;
    end else if (kick) begin
      state_nxt.cnt   = state_r.cnt_val;
      state_nxt.presc = '0;
      state_nxt.mins  = '0;
    end else if (state_r.fen && state_r.cnt != iwd_pkg::COUNT_RST) begin
      if (state_r.presc == PRESC_LAST) begin
        state_nxt.presc = '0;
        if (!state_r.unit[iwd_pkg::UNIT_MIN_BIT] || state_r.mins == MIN_LAST) begin
          state_nxt.mins = '0;
          unit_tick      = 1'b1;
        end else begin
          state_nxt.mins = state_r.mins + 1'b1;
        end
      end else begin
        state_nxt.presc = state_r.presc + 1'b1;
      end
    end

    if (unit_tick) begin
      state_nxt.cnt = state_r.cnt - 8'h01;
      expire        = (state_r.cnt == 8'h01);
    end

    // Set wins over a clear arriving in the same cycle
    if (clr_st) begin
      state_nxt.tout = 1'b0;
    end
    if (expire || force_to) begin
      state_nxt.tout = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= DEV_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign port.io_ack   = state_r.ack;
  assign port.io_rdata = state_r.rdata;
  assign wdt_alarm     = state_r.tout;

endmodule
`default_nettype wire

// ### iwd_pkg.sv
// Shared constants for the indexed-port watchdog timer and its host port engine
package iwd_pkg;

  // I/O port pair
  localparam logic [7:0] IDX_PORT   = 8'h2E;
  localparam logic [7:0] DAT_PORT   = 8'h2F;
  localparam logic [7:0] KEY_UNLOCK = 8'h87;
  localparam logic [7:0] KEY_LOCK   = 8'hAA;
  localparam logic [7:0] RD_IDLE    = 8'hFF;

  // Watchdog register indexes
  localparam logic [7:0] REG_BANK   = 8'h07;
  localparam logic [7:0] BANK_WDT   = 8'h08;
  localparam logic [7:0] REG_FEN    = 8'h30;
  localparam logic [7:0] FEN_ON     = 8'h01;
  localparam logic [7:0] REG_UNIT   = 8'hF5;
  localparam logic [7:0] REG_COUNT  = 8'hF6;
  localparam logic [7:0] REG_CTRL   = 8'hF7;

  // Field positions and reset values
  localparam int unsigned UNIT_MIN_BIT = 3;
  localparam int unsigned CTRL_MS_BIT  = 7;
  localparam int unsigned CTRL_KB_BIT  = 6;
  localparam int unsigned CTRL_FRC_BIT = 5;
  localparam int unsigned CTRL_ST_BIT  = 4;
  localparam logic [7:0] UNIT_RST   = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] BANK_RST   = 8'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned UNIT_TIME_S   = 1;
  localparam int unsigned NS_PER_S      = 1_000_000_000;
  localparam int unsigned CYC_PER_SEC   = UNIT_TIME_S * NS_PER_S / CLK_PERIOD_NS;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int unsigned MIN_W         = 6;

  // Host engine APB map
  localparam logic [11:0] HREG_CMD   = 12'h000;
  localparam logic [11:0] HREG_STAT  = 12'h004;
  localparam logic [11:0] HREG_ISTAT = 12'h008;
  localparam logic [11:0] HREG_IMASK = 12'h00C;
  localparam int unsigned CMD_DATA_LSB   = 0;
  localparam int unsigned CMD_ADDR_LSB   = 8;
  localparam int unsigned CMD_WE_BIT     = 16;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_RDATA_LSB = 8;
  localparam int unsigned EV_DONE_BIT    = 0;
  localparam int unsigned EV_REF_BIT     = 1;
  localparam int unsigned EV_W           = 2;

  typedef enum logic [1:0] {
    LK_LOCKED = 2'b00,
    LK_HALF   = 2'b01,
    LK_OPEN   = 2'b11
  } iwd_lock_e;

  typedef enum logic {
    HS_IDLE = 1'b0,
    HS_WAIT = 1'b1
  } iwd_hst_e;

endpackage

// ### iwd_if.sv
// Port-pair link between the host engine and the watchdog device
`timescale 1ns/1ps
`default_nettype none
interface iwd_if;
  logic       io_req;
  logic       io_we;
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic       io_ack;
  logic [7:0] io_rdata;

  modport dev (
    input  io_req,
    input  io_we,
    input  io_addr,
    input  io_wdata,
    output io_ack,
    output io_rdata
  );

  modport host (
    output io_req,
    output io_we,
    output io_addr,
    output io_wdata,
    input  io_ack,
    input  io_rdata
  );
endinterface
`default_nettype wire

// ### iwd_host.sv
// Host end: APB-programmed engine that issues single index/data port cycles
`timescale 1ns/1ps
`default_nettype none
module iwd_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  iwd_if.host              port
);

  typedef struct packed {
    iwd_pkg::iwd_hst_e            st;
    logic                         req;
    logic                         we;
    logic [7:0]                   addr;
    logic [7:0]                   wdata;
    logic [7:0]                   rdata;
    logic [iwd_pkg::EV_W-1:0]     istat;
    logic [iwd_pkg::EV_W-1:0]     imask;
    logic                         pready;
    logic                         slverr;
    logic [31:0]                  prdata;
    logic                         irq;
  } iwd_hst_s;

  iwd_hst_s                 state_r;
  iwd_hst_s                 state_nxt;
  logic                     acc;
  logic [iwd_pkg::EV_W-1:0] ev;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  always_comb begin
    state_nxt = state_r;
    state_nxt.pready = 1'b0;
    state_nxt.slverr = 1'b0;
    ev  = '0;
    acc = psel && penable && !state_r.pready;

    if (state_r.st == iwd_pkg::HS_WAIT && port.io_ack) begin
      state_nxt.req   = 1'b0;
      state_nxt.rdata = port.io_rdata;
      state_nxt.st    = iwd_pkg::HS_IDLE;
      ev[iwd_pkg::EV_DONE_BIT] = 1'b1;
    end

    if (acc) begin
      state_nxt.pready = 1'b1;
      state_nxt.prdata = '0;
      if (hit(paddr, iwd_pkg::HREG_CMD)) begin
        if (pwrite) begin
          // One port cycle at a time keeps key and index order as software issued it
          if (state_r.st == iwd_pkg::HS_IDLE) begin
            state_nxt.req   = 1'b1;
            state_nxt.we    = pwdata[iwd_pkg::CMD_WE_BIT];
            state_nxt.addr  = pwdata[iwd_pkg::CMD_ADDR_LSB +: 8];
            state_nxt.wdata = pwdata[iwd_pkg::CMD_DATA_LSB +: 8];
            state_nxt.st    = iwd_pkg::HS_WAIT;
          end else begin
            ev[iwd_pkg::EV_REF_BIT] = 1'b1;
          end
        end else begin
          state_nxt.prdata[iwd_pkg::CMD_WE_BIT]        = state_r.we;
          state_nxt.prdata[iwd_pkg::CMD_ADDR_LSB +: 8] = state_r.addr;
          state_nxt.prdata[iwd_pkg::CMD_DATA_LSB +: 8] = state_r.wdata;
        end
      end else if (hit(paddr, iwd_pkg::HREG_STAT)) begin
        // Last read byte lets software do read-modify-write of single bits
        state_nxt.prdata[iwd_pkg::STAT_BUSY_BIT]         = (state_r.st == iwd_pkg::HS_WAIT);
        state_nxt.prdata[iwd_pkg::STAT_RDATA_LSB +: 8]   = state_r.rdata;
      end else if (hit(paddr, iwd_pkg::HREG_ISTAT)) begin
        if (pwrite) begin
          state_nxt.istat = state_r.istat & ~pwdata[iwd_pkg::EV_W-1:0];
        end
        state_nxt.prdata[iwd_pkg::EV_W-1:0] = state_r.istat;
      end else if (hit(paddr, iwd_pkg::HREG_IMASK)) begin
        if (pwrite) begin
          state_nxt.imask = pwdata[iwd_pkg::EV_W-1:0];
        end
        state_nxt.prdata[iwd_pkg::EV_W-1:0] = state_r.imask;
      end else begin
        state_nxt.slverr = 1'b1;
      end
    end

    // Event set wins over a same-cycle clear
    state_nxt.istat = state_nxt.istat | ev;
    state_nxt.irq   = |(state_nxt.istat & state_nxt.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '{st: iwd_pkg::HS_IDLE, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata        = state_r.prdata;
  assign pready        = state_r.pready;
  assign pslverr       = state_r.slverr;
  assign irq           = state_r.irq;
  assign port.io_req   = state_r.req;
  assign port.io_we    = state_r.we;
  assign port.io_addr  = state_r.addr;
  assign port.io_wdata = state_r.wdata;

endmodule
`default_nettype wire

// ### iwd_chk.sv
// Assertions on the port link between host engine and watchdog device
`timescale 1ns/1ps
`default_nettype none
module iwd_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       io_req,
  input wire logic       io_we,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_ack,
  input wire logic [7:0] io_rdata,
  input wire logic       wdt_alarm
);
  logic       keys_r;
  logic       open_r;
  logic [7:0] idx_r;
  logic [7:0] bank_r;
  wire logic  acc = io_req && io_ack;
  wire logic  dat = acc && io_addr == iwd_pkg::DAT_PORT;
  wire logic  ctl = open_r && bank_r == iwd_pkg::BANK_WDT && idx_r == iwd_pkg::REG_CTRL;
  wire logic  rd_ok = io_rdata[iwd_pkg::CTRL_ST_BIT] == wdt_alarm && !io_rdata[iwd_pkg::CTRL_FRC_BIT];

  // Shadow of the key and bank state, updated when an access completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keys_r <= 1'b0;
      open_r <= 1'b0;
      idx_r  <= 8'h00;
      bank_r <= 8'h00;
    end else if (acc && io_we && io_addr == iwd_pkg::IDX_PORT) begin
      idx_r <= io_wdata;
      if (io_wdata == iwd_pkg::KEY_LOCK) begin
        open_r <= 1'b0;
        keys_r <= 1'b0;
      end else if (!open_r) begin
        open_r <= keys_r && io_wdata == iwd_pkg::KEY_UNLOCK;
        keys_r <= io_wdata == iwd_pkg::KEY_UNLOCK;
      end
    end else if (acc) begin
      keys_r <= 1'b0;
      if (dat && open_r && io_we && idx_r == iwd_pkg::REG_BANK) begin
        bank_r <= io_wdata;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ack_follows: assert property ($rose(io_req) |=> io_ack)
    else $error("no acknowledge one cycle after request");
  chk_ack_single: assert property (io_ack |=> !io_ack)
    else $error("acknowledge longer than one cycle");
  chk_ack_cause: assert property (io_ack |-> io_req && !$past(io_ack))
    else $error("acknowledge without pending request");
  chk_req_release: assert property (io_ack |=> !io_req)
    else $error("request not released after acknowledge");
  chk_req_stable: assert property (io_req && !io_ack |=> io_req && $stable({io_we, io_addr, io_wdata}))
    else $error("request changed before acknowledge");
  chk_locked_read: assert property (dat && !io_we && !open_r |-> io_rdata == iwd_pkg::RD_IDLE)
    else $error("data read while locked not idle value");
  chk_force_alarm: assert property (dat && io_we && ctl && io_wdata[iwd_pkg::CTRL_FRC_BIT] |=> wdt_alarm)
    else $error("forced timeout did not raise alarm");
  chk_status_read: assert property (dat && !io_we && ctl && $stable(wdt_alarm) |-> rd_ok)
    else $error("control read disagrees with alarm");

  cover property (dat && io_we && ctl);
  cover property ($rose(wdt_alarm));
  cover property (dat && !io_we && !open_r);
endmodule
`default_nettype wire

// ### indexed_port_watchdog_timer_tb.sv
// Self-checking bench: APB host engine driving the watchdog device
`timescale 1ns/1ps
`default_nettype none
module indexed_port_watchdog_timer_tb;
  localparam int CPS = 10;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        kbd_act = 1'b0;
  logic        mouse_act = 1'b0;
  logic        wdt_alarm;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  v;
  integer      seed = 32'h98c8560d;
  int          mismatches = 0;
  int          checked = 0;
  int          n;

  iwd_if link ();
  iwd_host i_iwd_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .port(link.host));
  iwd_device #(.CYC_PER_SEC(CPS)) i_iwd_device (.pclk(pclk), .presetn(presetn), .port(link.dev),
    .kbd_act(kbd_act), .mouse_act(mouse_act), .wdt_alarm(wdt_alarm));
  iwd_chk i_iwd_chk (.pclk(pclk), .presetn(presetn), .io_req(link.io_req), .io_we(link.io_we),
    .io_addr(link.io_addr), .io_wdata(link.io_wdata), .io_ack(link.io_ack), .io_rdata(link.io_rdata),
    .wdt_alarm(wdt_alarm));

  always #5 pclk = ~pclk;

  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(int c);
    repeat (c) @(posedge pclk);
  endtask

  // Control read-back: force bit never reads as one
  function automatic logic [7:0] exp_ctrl(logic [7:0] w, logic st);
    return {w[7:6], 1'b0, st, w[3:0]};
  endfunction

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One port cycle; waits on busy so the next command is never dropped
  task automatic io(logic we, logic [7:0] a, logic [7:0] d);
    apb(1'b1, iwd_pkg::HREG_CMD, {15'h0000, we, a, d});
    do apb(1'b0, iwd_pkg::HREG_STAT, 0); while (rd[iwd_pkg::STAT_BUSY_BIT] !== 1'b0);
    v = rd[15:8];
  endtask

  task automatic wr(logic [7:0] i, logic [7:0] d);
    io(1'b1, iwd_pkg::IDX_PORT, i);
    io(1'b1, iwd_pkg::DAT_PORT, d);
  endtask

  task automatic rdr(logic [7:0] i);
    io(1'b1, iwd_pkg::IDX_PORT, i);
    io(1'b0, iwd_pkg::DAT_PORT, 8'h00);
  endtask

  task automatic unlock();
    io(1'b1, iwd_pkg::IDX_PORT, iwd_pkg::KEY_UNLOCK);
    io(1'b1, iwd_pkg::IDX_PORT, iwd_pkg::KEY_UNLOCK);
    wr(iwd_pkg::REG_BANK, iwd_pkg::BANK_WDT);
  endtask

  task automatic kick(int s);
    cyc(20);
    {mouse_act, kbd_act} <= (s != 0) ? 2'b10 : 2'b01;
    @(posedge pclk);
    {mouse_act, kbd_act} <= 2'b00;
  endtask

  initial begin
    #200_000;
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, iwd_pkg::HREG_IMASK, 0);
    check("imask", rd, 0);
    apb(1'b0, 12'h010, 0);
    check("pslverr", err, 1);
    apb(1'b1, iwd_pkg::HREG_IMASK, 1);
    io(1'b0, iwd_pkg::DAT_PORT, 8'h00);
    check("locked read", v, 8'hFF);
    apb(1'b0, iwd_pkg::HREG_CMD, 0);
    check("last command", rd, {16'h0000, iwd_pkg::DAT_PORT, 8'h00});
    check("irq", irq, 1);
    apb(1'b1, iwd_pkg::HREG_ISTAT, 1);
    apb(1'b1, iwd_pkg::HREG_IMASK, 0);
    check("irq cleared", irq, 0);
    io(1'b1, iwd_pkg::IDX_PORT, iwd_pkg::KEY_UNLOCK);
    io(1'b0, iwd_pkg::DAT_PORT, 8'h00);
    io(1'b1, iwd_pkg::IDX_PORT, iwd_pkg::KEY_UNLOCK);
    io(1'b0, iwd_pkg::DAT_PORT, 8'h00);
    check("split keys", v, 8'hFF);
    unlock();
    for (int i = 0; i < 3; i++) begin
      rdr(iwd_pkg::REG_UNIT + 8'(i));
      check("reset value", v, 0);
    end
    io(1'b0, iwd_pkg::IDX_PORT, 8'h00);
    check("index read", v, iwd_pkg::REG_CTRL);
    io(1'b0, 8'h80, 8'h00);
    check("other port", v, 8'hFF);
    wr(iwd_pkg::REG_FEN, iwd_pkg::FEN_ON);
    n = 2 + ($unsigned($random(seed)) % 4);
    wr(8'hF6, 8'(n));
    cyc(n * CPS - 10);
    check("early", wdt_alarm, 0);
    cyc(20);
    check("expiry", wdt_alarm, 1);
    wr(8'hF7, 8'h10);
    wr(8'hF6, 8'h05);
    cyc(20);
    io(1'b1, iwd_pkg::DAT_PORT, 8'h05);
    cyc(30);
    check("restart", wdt_alarm, 0);
    cyc(20);
    check("restart expiry", wdt_alarm, 1);
    for (int s = 0; s < 2; s++) begin
      wr(8'hF7, (s != 0) ? 8'h90 : 8'h50);
      wr(8'hF6, 8'h03);
      repeat (4) kick(s);
      check("kicked", wdt_alarm, 0);
      wr(8'hF7, 8'h00);
      wr(8'hF6, 8'h03);
      kick(s);
      cyc(10);
      check("kick ignored", wdt_alarm, 1);
      wr(8'hF7, 8'h10);
    end
    n = $random(seed);
    wr(8'hF7, 8'h20);
    check("force", wdt_alarm, 1);
    rdr(8'hF7);
    check("force read", v, exp_ctrl(8'h20, 1'b1));
    wr(8'hF7, {4'h1, n[3:0]});
    rdr(8'hF7);
    check("control read", v, exp_ctrl({4'h1, n[3:0]}, 1'b0));
    rdr(8'hF5);
    wr(8'hF5, v | 8'h08);
    rdr(8'hF5);
    check("unit", v & 8'h08, 8'h08);
    wr(8'hF6, 8'h01);
    cyc(580);
    check("minute early", wdt_alarm, 0);
    cyc(40);
    check("minute expiry", wdt_alarm, 1);
    wr(8'hF7, 8'h10);
    wr(8'hF5, 8'h00);
    wr(8'hF6, 8'h00);
    cyc(60);
    check("stopped", wdt_alarm, 0);
    wr(iwd_pkg::REG_FEN, 8'h00);
    wr(8'hF6, 8'h02);
    cyc(40);
    check("disabled", wdt_alarm, 0);
    rdr(8'hF6);
    check("count held", v, 2);
    wr(iwd_pkg::REG_FEN, iwd_pkg::FEN_ON);
    cyc(40);
    check("enabled", wdt_alarm, 1);
    wr(8'hF7, 8'h10);
    wr(iwd_pkg::REG_BANK, 8'h00);
    rdr(8'hF6);
    check("other bank", v, 8'hFF);
    io(1'b1, iwd_pkg::IDX_PORT, iwd_pkg::KEY_LOCK);
    wr(8'hF6, 8'h09);
    rdr(8'hF6);
    check("locked", v, 8'hFF);
    unlock();
    rdr(8'hF6);
    check("write dropped", v, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
